// file: core/bitbang_parallel_port.sv
// Purpose: byte-wide bit-bang port, async and sync modes
// Assumes: host bytes and samples move by valid/ready streams
// Notes: setup writes abort any sequence in progress
module bitbang_parallel_port (
  input wire logic i_mclk, // system clock
  input wire logic i_reset, // sync reset, active high
  input wire bbp_pkg::addr_t i_addr, // register word address
  input wire bbp_pkg::word_t i_wdata, // register write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output bbp_pkg::word_t o_rdata, // read data, cycle after i_rd
  input wire logic i_host_valid, // byte from host valid
  input wire bbp_pkg::byte_t i_host_data, // byte from host
  output logic o_host_ready, // buffer can take a byte
  output logic o_samp_valid, // pin sample toward host valid
  output bbp_pkg::byte_t o_samp_data, // pin sample toward host
  input wire logic i_samp_ready, // host takes the sample
  bbp_if.dev pins // parallel pins and strobes
);
  import bbp_pkg::*;

  byte_t mode_r;
  byte_t dir_r;
  word_t baud_div_r;
  word_t baud_cnt_r;
  logic baud_tick;
  byte_t out_r;
  byte_t samp_r;
  logic samp_valid_r;
  logic rd_n_r;
  logic wr_n_r;
  seq_state_e state_r;
  seq_state_e state_nxt;
  byte_t mem_r [`BBP_FIFO_DEPTH];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;
  logic setup_wr;
  logic is_async;
  logic is_sync;
  logic async_out;
  logic async_samp;
  word_t rdata_r;

  assign setup_wr = i_wr && (i_addr == `BBP_ADDR_SETUP);
  // [RULE_06] async mode code
  assign is_async = (mode_r == `BBP_MODE_ASYNC);
  // [RULE_12] sync mode code
  assign is_sync = (mode_r == `BBP_MODE_SYNC);

  // [RULE_15] mode and mask held until next setup
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      mode_r <= `BBP_MODE_OFF;
      dir_r <= `BBP_DIR_RST;
    end else if (setup_wr) begin
      mode_r <= i_wdata[`BBP_SETUP_MODE_LSB +: 8];
      dir_r <= i_wdata[`BBP_SETUP_DIR_LSB +: 8];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      baud_div_r <= `BBP_BAUD_RST;
    end else if (i_wr && (i_addr == `BBP_ADDR_BAUD)) begin
      baud_div_r <= i_wdata;
    end
  end

  // [RULE_04] baud tick every divisor+1 cycles
  always_ff @(posedge i_mclk) begin
    if (i_reset || setup_wr || !is_async) begin
      baud_cnt_r <= 16'h0000;
    end else if (baud_cnt_r == 16'h0000) begin
      baud_cnt_r <= baud_div_r;
    end else begin
      baud_cnt_r <= baud_cnt_r - 16'h0001;
    end
  end
  assign baud_tick = is_async && (baud_cnt_r == 16'h0000);

  // two-entry buffer; ready drops when both entries hold data
  assign o_host_ready = (cnt_r != 2'h2);
  assign push = i_host_valid && o_host_ready;

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_host_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      case ({push, pop})
        2'b10: cnt_r <= cnt_r + 2'h1;
        2'b01: cnt_r <= cnt_r - 2'h1;
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // [RULE_05] async output moves only with a byte and a tick
  assign async_out = baud_tick && (cnt_r != 2'h0) && !setup_wr;
  assign async_samp = baud_tick && !samp_valid_r && !setup_wr;
  // [RULE_07] sync byte leaves buffer only in update step
  assign pop = async_out || (is_sync && (state_r == ST_UPDATE) && !setup_wr);

  // [RULE_10] start only with a byte and room toward host
  // [RULE_09] a sample starts only from a pending write
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (is_sync && (cnt_r != 2'h0) && !samp_valid_r) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: state_nxt = ST_UPDATE;
      ST_UPDATE: state_nxt = ST_SETUP;
      ST_SETUP: state_nxt = ST_STROBE;
      ST_STROBE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // [RULE_13] sample, update, one setup cycle, strobe
  always_ff @(posedge i_mclk) begin
    if (i_reset || setup_wr) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // [RULE_02] async byte goes straight to the output latch
  // [RULE_11] sync update follows the sample step
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      out_r <= 8'h00;
    end else if (pop) begin
      out_r <= mem_r[rd_ptr_r];
    end
  end

  // [RULE_11] pins captured before the new byte lands
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      samp_r <= 8'h00;
    end else if (async_samp || (is_sync && (state_r == ST_SAMPLE) && !setup_wr)) begin
      samp_r <= pins.level;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset || setup_wr) begin
      samp_valid_r <= 1'b0;
    end else if (async_samp || (is_sync && (state_r == ST_SAMPLE))) begin
      samp_valid_r <= 1'b1;
    end else if (i_samp_ready) begin
      samp_valid_r <= 1'b0;
    end
  end

  // [RULE_14] sample strobe rises as the sample is queued in async, one cycle before it in sync
  // [RULE_01] async ticks with no sample pending pulse the exported sample strobe
  always_ff @(posedge i_mclk) begin
    if (i_reset || setup_wr) begin
      rd_n_r <= 1'b0;
    end else if (is_sync) begin
      // [RULE_13] released from sample until the new byte lands
      rd_n_r <= (state_nxt == ST_SAMPLE) || (state_nxt == ST_UPDATE);
    end else begin
      rd_n_r <= async_samp;
    end
  end

  // [RULE_08] update strobe low once the byte is on the pins
  // [RULE_01] async byte updates pulse the update strobe
  always_ff @(posedge i_mclk) begin
    if (i_reset || setup_wr) begin
      wr_n_r <= 1'b1;
    end else if (is_sync) begin
      wr_n_r <= !(state_r == ST_SETUP);
    end else begin
      wr_n_r <= !async_out;
    end
  end

  // [RULE_03] each mask bit sets its own pin direction
  // [RULE_17] input pins stay undriven
  assign pins.dev_oe = dir_r;
  assign pins.dev_out = out_r;
  assign pins.pin_sample_strobe_n = rd_n_r;
  assign pins.pin_update_strobe_n = wr_n_r;

  assign o_samp_valid = samp_valid_r;
  assign o_samp_data = samp_r;

  // unmapped addresses read as zero
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rdata_r <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        `BBP_ADDR_SETUP: rdata_r <= {dir_r, mode_r};
        `BBP_ADDR_BAUD: rdata_r <= baud_div_r;
        `BBP_ADDR_STATUS: rdata_r <= {out_r, pins.level};
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end
  assign o_rdata = rdata_r;
endmodule : bitbang_parallel_port

// file: core/bbp_cfg.svh
// Purpose: constants for the bit-bang parallel port and its partner logic
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes: register port is 4-bit word address, 16-bit data
//
// Summary of operation
// [RULE_01] async mode exports sample and update strobes
// [RULE_02] async mode drives host bytes onto outputs
// [RULE_03] each pin individually input or output
// [RULE_04] async output pace set by baud ticks
// [RULE_05] outputs change only on new byte plus tick
// [RULE_06] mode code 01h selects async mode
// [RULE_07] sync mode updates pins only per byte
// [RULE_08] sync update strobe when byte reaches pins
// [RULE_09] sync sample only caused by a write
// [RULE_10] sync waits for room toward host
// [RULE_11] sync samples pins before applying byte
// [RULE_12] mode code 04h selects sync mode
// [RULE_13] sample, release, update, wait, strobe pulse
// [RULE_14] sample strobe rising edge marks capture; in sync mode the strobe rises one cycle before the pins are captured
// [RULE_15] direction mask held until next setup
// [RULE_16] host writes a byte per wanted sample
// [RULE_17] input pins undriven and sampled as-is
`ifndef BBP_CFG_SVH
`define BBP_CFG_SVH

`define BBP_MODE_OFF 8'h00
`define BBP_MODE_ASYNC 8'h01
`define BBP_MODE_SYNC 8'h04

`define BBP_ADDR_SETUP 4'h0
`define BBP_ADDR_BAUD 4'h1
`define BBP_ADDR_STATUS 4'h2

`define BBP_SETUP_MODE_LSB 0
`define BBP_SETUP_DIR_LSB 8

`define BBP_DIR_RST 8'h00
`define BBP_BAUD_RST 16'h0007
`define BBP_FIFO_DEPTH 2

`endif

// file: core/bbp_pkg.sv
// Purpose: shared types of the bit-bang parallel port
// Assumes: bbp_cfg.svh on the include path
// Notes: sequencer states are Gray coded along the sync path, except strobe back to idle
`include "bbp_cfg.svh"

package bbp_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
  typedef logic [3:0] addr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SAMPLE = 3'h1,
    ST_UPDATE = 3'h3,
    ST_SETUP = 3'h2,
    ST_STROBE = 3'h6
  } seq_state_e;
endpackage : bbp_pkg

// file: core/bbp_if.sv
// Purpose: pin bundle between the port and the external logic
// Assumes: pins pulled high when nobody drives them
// Notes: device drive wins if both sides enable a pin
interface bbp_if;
  logic [7:0] dev_out;
  logic [7:0] dev_oe;
  logic [7:0] ext_out;
  logic [7:0] ext_oe;
  logic [7:0] level;
  logic pin_sample_strobe_n;
  logic pin_update_strobe_n;

  assign level = (dev_oe & dev_out) | (~dev_oe & ext_oe & ext_out) | (~dev_oe & ~ext_oe);

  modport dev (
    output dev_out, dev_oe, pin_sample_strobe_n, pin_update_strobe_n,
    input level
  );
  modport ext (
    output ext_out, ext_oe,
    input level, pin_sample_strobe_n, pin_update_strobe_n
  );
endinterface : bbp_if

// file: core/ext_pin_logic.sv
// Purpose: external logic clocked by the port's strobes
// Assumes: strobes arrive synchronous to i_mclk
// Notes: drives only pins it enables; captures on strobe edges
module ext_pin_logic (
  input wire logic i_mclk, // system clock
  input wire logic i_reset, // sync reset, active high
  input wire bbp_pkg::byte_t i_drive_val, // value for pins this side drives
  input wire bbp_pkg::byte_t i_drive_en, // per-pin drive enable
  output bbp_pkg::byte_t o_captured, // pins seen at update strobe rise
  output bbp_pkg::word_t o_update_count, // update strobe pulses seen
  output bbp_pkg::word_t o_sample_count, // sample strobe rising edges seen
  bbp_if.ext pins // parallel pins and strobes
);
  import bbp_pkg::*;

  logic wr_n_prev_r;
  logic rd_n_prev_r;
  byte_t cap_r;
  word_t upd_cnt_r;
  word_t smp_cnt_r;

  // this side drives only the pins it owns; the rest stay released
  assign pins.ext_out = i_drive_val;
  assign pins.ext_oe = i_drive_en;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      wr_n_prev_r <= 1'b1;
      rd_n_prev_r <= 1'b0;
    end else begin
      wr_n_prev_r <= pins.pin_update_strobe_n;
      rd_n_prev_r <= pins.pin_sample_strobe_n;
    end
  end

  // [RULE_08] rise of the update strobe ends a write
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cap_r <= 8'h00;
      upd_cnt_r <= 16'h0000;
    end else if (pins.pin_update_strobe_n && !wr_n_prev_r) begin
      cap_r <= pins.level;
      upd_cnt_r <= upd_cnt_r + 16'h0001;
    end
  end

  // [RULE_14] sample strobe rise counts one capture
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      smp_cnt_r <= 16'h0000;
    end else if (pins.pin_sample_strobe_n && !rd_n_prev_r) begin
      smp_cnt_r <= smp_cnt_r + 16'h0001;
    end
  end

  assign o_captured = cap_r;
  assign o_update_count = upd_cnt_r;
  assign o_sample_count = smp_cnt_r;
endmodule : ext_pin_logic

// file: verif/bbp_properties.sv
// Purpose: pin-side properties of the bit-bang port
// Assumes: one clock, sync active-high reset
// Notes: sees only the pin bundle, so rules tied to the mode stay in the bench
module bbp_properties (
  input wire logic i_mclk, // clock
  input wire logic i_reset, // reset, active high
  input wire logic [7:0] i_dev_out, // device latch
  input wire logic [7:0] i_dev_oe, // device enables
  input wire logic [7:0] i_ext_out, // far-end drive
  input wire logic [7:0] i_ext_oe, // far-end enables
  input wire logic [7:0] i_level, // resolved pins
  input wire logic i_pin_sample_strobe_n, // sample strobe
  input wire logic i_pin_update_strobe_n // update strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  property p_upd_pulse; $fell(i_pin_update_strobe_n) |=> i_pin_update_strobe_n; endproperty
  a_upd_pulse: assert property (p_upd_pulse)
    else $error("update strobe wider than one cycle");
  property p_out_strobed; $changed(i_dev_out) |-> ##[0:1] !i_pin_update_strobe_n; endproperty
  a_out_strobed: assert property (p_out_strobed)
    else $error("outputs changed without update strobe");
  property p_out_hold; $fell(i_pin_update_strobe_n) |=> $stable(i_dev_out); endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("outputs moved right after update strobe");
  property p_smp_width;
    $rose(i_pin_sample_strobe_n) |-> ##[1:2] !i_pin_sample_strobe_n;
  endproperty
  a_smp_width: assert property (p_smp_width)
    else $error("sample strobe high too long");
  property p_dir_idle;
    $changed(i_dev_oe) |-> i_pin_update_strobe_n && !i_pin_sample_strobe_n;
  endproperty
  a_dir_idle: assert property (p_dir_idle)
    else $error("direction changed with strobes busy");
  property p_rst_in; $fell(i_reset) |-> i_dev_oe == 8'h00 && i_pin_update_strobe_n; endproperty
  a_rst_in: assert property (p_rst_in)
    else $error("pins not inputs after reset");
  property p_drv_out; ((i_level ^ i_dev_out) & i_dev_oe) == 8'h00; endproperty
  a_drv_out: assert property (p_drv_out)
    else $error("output pin not at latch value");
  property p_in_free; ((i_level ^ i_ext_out) & i_ext_oe & ~i_dev_oe) == 8'h00; endproperty
  a_in_free: assert property (p_in_free)
    else $error("input pin driven by device");
endmodule : bbp_properties

// file: verif/testbench.sv
// Purpose: self-checking bench for the port and its far-end logic
// Assumes: 125 MHz clock, sync reset held six cycles
// Notes: samples and reads checked against queues of expected values
`include "bbp_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bbp_pkg::*;
  logic i_mclk, i_reset, i_wr, i_rd, i_host_valid, i_samp_ready, o_host_ready, o_samp_valid;
  logic chk_en, stall, rd_d;
  logic [31:0] rs;
  addr_t i_addr;
  word_t i_wdata, o_rdata, upd_cnt, smp_cnt, u0, s0;
  byte_t i_host_data, o_samp_data, drv_val, drv_en, cap, dir, prev;
  int error_cnt, compares, cyc, t1;
  byte_t exp_q[$];
  word_t rd_q[$];
  word_t cfg[3] = '{16'hFF00, 16'h0FF0, 16'h00FF};
  bbp_if pins_if();
  bitbang_parallel_port u_bitbang_parallel_port (.i_mclk, .i_reset, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_host_valid, .i_host_data, .o_host_ready, .o_samp_valid,
    .o_samp_data, .i_samp_ready, .pins(pins_if));
  ext_pin_logic u_ext_pin_logic (.i_mclk, .i_reset, .i_drive_val(drv_val),
    .i_drive_en(drv_en), .o_captured(cap), .o_update_count(upd_cnt),
    .o_sample_count(smp_cnt), .pins(pins_if));
  bbp_properties u_bbp_properties (.i_mclk, .i_reset, .i_dev_out(pins_if.dev_out),
    .i_dev_oe(pins_if.dev_oe), .i_ext_out(pins_if.ext_out), .i_ext_oe(pins_if.ext_oe),
    .i_level(pins_if.level), .i_pin_sample_strobe_n(pins_if.pin_sample_strobe_n),
    .i_pin_update_strobe_n(pins_if.pin_update_strobe_n));
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input word_t got, input word_t exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic tmo();
    error_cnt++;
    finish_test();
  endtask : tmo
  task automatic wr(input addr_t a, input word_t d);
    @(posedge i_mclk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input addr_t a, input word_t e);
    @(posedge i_mclk);
    {i_rd, i_addr} <= {1'b1, a};
    rd_q.push_back(e);
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask : rd
  task automatic push(input byte_t b);
    @(posedge i_mclk);
    {i_host_valid, i_host_data} <= {1'b1, b};
    for (int i = 0; i < 300; i++) begin
      @(posedge i_mclk);
      if (o_host_ready === 1'b1) break;
    end
    if (o_host_ready !== 1'b1) tmo();
    i_host_valid <= 1'b0;
  endtask : push
  // pins read before the byte lands, so each note is the previous state
  task automatic sync_bytes(input int n);
    repeat (n) begin
      exp_q.push_back((prev & dir) | (~dir & (drv_val | ~drv_en)));
      prev = rs[15:8];
      push(prev);
    end
  endtask : sync_bytes
  task automatic wait_upd(input word_t n);
    for (int i = 0; upd_cnt !== n || exp_q.size() != 0; i++) begin
      if (i == 600) tmo();
      @(posedge i_mclk);
    end
  endtask : wait_upd
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    rs <= lfsr(rs);
    i_samp_ready <= !stall && (!chk_en || rs[4]);
    rd_d <= i_rd;
    if (rd_d) chk(o_rdata, rd_q.pop_front());
    if (chk_en && o_samp_valid && i_samp_ready)
      chk({8'h00, o_samp_data}, {8'h00, exp_q.pop_front()});
  end
  initial begin
    {i_reset, i_wr, i_rd, i_host_valid, i_samp_ready, stall, chk_en, rd_d} = 8'h80;
    {i_addr, i_wdata, i_host_data, drv_val, drv_en, prev} = '0;
    rs = 32'h9C85314C;
    {error_cnt, compares, cyc} = '0;
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    rd(`BBP_ADDR_STATUS, 16'h00FF);
    rd(4'hF, 16'h0000);
    repeat (2) @(posedge i_mclk);
    $display("reset test done");
    chk_en <= 1'b1;
    foreach (cfg[k]) begin
      dir = cfg[k][15:8];
      {drv_en, drv_val} <= {cfg[k][7:0], rs[23:16]};
      wr(`BBP_ADDR_SETUP, {dir, `BBP_MODE_SYNC});
      {u0, s0} = {upd_cnt, smp_cnt};
      sync_bytes(6);
      wait_upd(u0 + 16'd6);
      repeat (8) @(posedge i_mclk);
      chk(upd_cnt - u0, 16'd6);
      chk(smp_cnt - s0, 16'd6);
      chk({8'h00, cap & dir}, {8'h00, prev & dir});
      $display("sync test %0d done", k);
    end
    // stalled sample path must block the sequencer and fill the buffer
    {stall, drv_en} <= {1'b1, 8'h00};
    dir = 8'hFF;
    wr(`BBP_ADDR_SETUP, {dir, `BBP_MODE_SYNC});
    u0 = upd_cnt;
    sync_bytes(3);
    repeat (10) @(posedge i_mclk);
    chk({15'h0000, o_host_ready}, 16'h0000);
    chk(upd_cnt - u0, 16'd1);
    stall <= 1'b0;
    wait_upd(u0 + 16'd3);
    $display("stall test done");
    chk_en <= 1'b0;
    wr(`BBP_ADDR_BAUD, 16'h0003);
    wr(`BBP_ADDR_SETUP, {8'hFF, `BBP_MODE_ASYNC});
    {u0, s0} = {upd_cnt, smp_cnt};
    push(8'h3C);
    push(8'hC3);
    wait_upd(u0 + 16'd1);
    t1 = cyc;
    wait_upd(u0 + 16'd2);
    chk(16'(cyc - t1), 16'd4);
    chk({8'h00, cap}, 16'h00C3);
    repeat (20) @(posedge i_mclk);
    chk(upd_cnt - u0, 16'd2);
    chk({15'h0000, smp_cnt != s0}, 16'h0001);
    rd(`BBP_ADDR_STATUS, 16'hC3C3);
    repeat (3) @(posedge i_mclk);
    $display("async test done");
    // mode off: byte is buffered but never reaches the pins
    wr(`BBP_ADDR_SETUP, {8'hFF, `BBP_MODE_OFF});
    push(8'h5A);
    s0 = smp_cnt;
    repeat (20) @(posedge i_mclk);
    chk(upd_cnt - u0, 16'd2);
    chk(smp_cnt - s0, 16'd0);
    chk({8'h00, pins_if.dev_out}, 16'h00C3);
    $display("mode off test done");
    finish_test();
  end
endmodule : testbench
